// ---- rtl/umb_cfg.svh ----
// register offsets, field positions, reset values and divider constants for the uart baud / multiproc block
// assumes inclusion by bare name from the package and the bench
`ifndef UMB_CFG_SVH
`define UMB_CFG_SVH
// ****************************************
// register byte addresses
// ****************************************
`define UMB_ADDR_CTRL 12'h000
`define UMB_ADDR_BAUD 12'h004
`define UMB_ADDR_BAUD_CONTROL 12'h008
`define UMB_ADDR_RXBUF 12'h00c
// ****************************************
// field positions
// ****************************************
`define UMB_CTRL_MODE_LSB 0
`define UMB_CTRL_MODE_MSB 1
`define UMB_CTRL_MPF 2
`define UMB_CTRL_RXF 3
`define UMB_CTRL_RB8 4
`define UMB_BAUD_CONTROL_RUN 0
`define UMB_BAUD_CONTROL_PRE_LSB 1
`define UMB_BAUD_CONTROL_PRE_MSB 3
`define UMB_BAUD_FRAC_MSB 4
`define UMB_BAUD_RELOAD_LSB 5
`define UMB_BAUD_RELOAD_MSB 15
// ****************************************
// reset values and dividers
// ****************************************
`define UMB_RST_RELOAD 11'h000
`define UMB_RST_FRAC 5'h00
`define UMB_RST_PRE 3'h0
`define UMB_RST_MODE 2'h0
`define UMB_DIV_MODE0 7'h02
`define UMB_DIV_MODE2 7'h40
`define UMB_OVERSAMPLE 4'hf
`define UMB_FRAC_STEPS 6'h20
`define UMB_PCLK_HZ 40000000
`endif

// ---- rtl/umb_core.sv ----
// uart baud-rate generator and multiprocessor receive filter with an apb register slave
// assumes a frame deserialiser on pclk presents finished frames as one-cycle pulses
//
// Overview of operation
// - nine-bit modes receive nine data bits; ninth bit stored in rx_ninth_bit, one stop
// - filter set in nine-bit modes: complete event only when ninth bit is one
// - filter enable has no effect in shift register mode
// - eight-bit mode with filter: complete event only with valid stop bit
// - shift mode runs pclk/2, fixed nine-bit mode pclk/64
// - eight-bit and variable nine-bit modes use programmable generator timing
// - generator gives sixteen times bit rate; interface divides by sixteen
// - eleven-bit reload, three-bit prescaler select, five-bit fractional select
// - baud timer counts down on prescaled clock only while baud_run set
// - each underflow emits one pulse and reloads from reload_value
// - fraction n: one extra count on n of every 32 periods
// - read returns timer count; low byte write updates reload register
// - writes to baud register ignored while baud_run is set
// - timer loaded from reload register one cycle after baud_run set
// - bit rate = pclk / (16 * prescale * (reload + n/32))
// - prescale select 000,001,010,011 gives 1,2,4,8
// - baud register: reload in upper eleven bits, fraction in low five
// - generator modes: bit rate at most pclk/32; reload 0 or 1 here gives up to pclk/16
// - two mode bits select shift, async8, fixed nine, variable nine
// - complete flag set only when clear; otherwise byte is lost
`timescale 1ns/1ps
module umb_core #(
  parameter int RELOAD_W = 11,
  parameter int FRAC_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire umb_pkg::umb_frame_t rx_frame,
  input wire logic rx_stop_bit,
  output logic baud_x16_pulse,
  output logic bit_tick,
  output logic rx_complete_flag,
  output logic rx_ninth_bit,
  output logic [7:0] rx_data
);

  // ****************************************
  // state
  // ****************************************
  umb_pkg::umb_mode_t mode_r;
  logic multiproc_filter_enable_r;
  logic baud_run_r;
  logic [2:0] baud_prescale_sel_r;
  umb_pkg::umb_baud_t reload_r;
  logic [RELOAD_W-1:0] timer_r;
  logic [FRAC_W-1:0] frac_acc_r;
  logic extra_r;
  logic [7:0] pre_cnt_r;
  logic run_d_r;
  logic [6:0] fix_cnt_r;
  logic [3:0] os_cnt_r;
  logic gen_pulse;
  logic pre_tick;
  logic fix_pulse;
  logic x16_nxt;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rdata_nxt;
  logic addr_ok;
  logic [FRAC_W:0] frac_sum;

  // prescale factor from select code; codes above 011 clamp to 8
  function automatic logic [7:0] pre_div(input logic [2:0] sel);
    logic [7:0] d;
    d = 8'h01;
    if (sel <= 3'h3) begin
      d = 8'(8'h01 << sel);
    end else begin
      d = 8'h08;
    end
    return d;
  endfunction

  function automatic logic var_mode(input umb_pkg::umb_mode_t m);
    return (m == umb_pkg::UMB_MODE_ASYNC8) || (m == umb_pkg::UMB_MODE_VAR9);
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // ****************************************
  // prescaler
  // ****************************************
  // free divide of pclk, only runs with the generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (!baud_run_r || pre_tick) begin
      pre_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end
  assign pre_tick = baud_run_r && (pre_cnt_r == pre_div(baud_prescale_sel_r) - 8'h01);

  // ****************************************
  // baud timer
  // ****************************************
  // underflow when timer at 1 and no pending extra count; period = reload (+1)
  // no pulse in the load cycle: a stale count of one would fire a short period
  assign gen_pulse = pre_tick && (timer_r <= RELOAD_W'(1)) && !extra_r && !(baud_run_r && !run_d_r);
  assign frac_sum = {1'b0, frac_acc_r} + {1'b0, reload_r.frac};

  // run delay register gives the one-cycle late load after start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= baud_run_r;
    end
  end

  // counting down, reload on underflow, extra cycle steered by accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= `UMB_RST_RELOAD;
      frac_acc_r <= `UMB_RST_FRAC;
      extra_r <= 1'b0;
    end else if (baud_run_r && !run_d_r) begin
      timer_r <= reload_r.reload;
      frac_acc_r <= `UMB_RST_FRAC;
      extra_r <= 1'b0;
    end else if (pre_tick) begin
      if (timer_r <= RELOAD_W'(1) && extra_r) begin
        extra_r <= 1'b0;
      end else if (timer_r <= RELOAD_W'(1)) begin
        timer_r <= reload_r.reload;
        // accumulator overflow spreads n extras over 32 periods
        frac_acc_r <= frac_sum[FRAC_W-1:0];
        extra_r <= frac_sum[FRAC_W];
      end else begin
        timer_r <= timer_r - RELOAD_W'(1);
      end
    end
  end

  // ****************************************
  // fixed dividers and x16 clock
  // ****************************************
  // shift mode ticks every 2 clocks; fixed nine-bit gives 64 per bit, so x16 every 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_cnt_r <= 7'h00;
    end else if (fix_pulse) begin
      fix_cnt_r <= 7'h00;
    end else begin
      fix_cnt_r <= fix_cnt_r + 7'h01;
    end
  end
  // compare with >= so a mode change never leaves the counter past its end
  assign fix_pulse = (mode_r == umb_pkg::UMB_MODE_SHIFT) ?
    (fix_cnt_r >= `UMB_DIV_MODE0 - 7'h01) :
    (fix_cnt_r >= 7'(`UMB_DIV_MODE2 >> 4) - 7'h01);

  // variable modes take the generator, fixed nine-bit its divider
  assign x16_nxt = var_mode(mode_r) ? gen_pulse :
    ((mode_r == umb_pkg::UMB_MODE_FIX9) && fix_pulse);

  // divide by sixteen into the bit rate; shift mode ticks straight at pclk/2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt_r <= 4'h0;
      baud_x16_pulse <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      baud_x16_pulse <= x16_nxt;
      if (mode_r == umb_pkg::UMB_MODE_SHIFT) begin
        os_cnt_r <= 4'h0;
        bit_tick <= fix_pulse;
      end else if (x16_nxt) begin
        os_cnt_r <= os_cnt_r + 4'h1;
        bit_tick <= (os_cnt_r == `UMB_OVERSAMPLE);
      end else begin
        bit_tick <= 1'b0;
      end
    end
  end

  // ****************************************
  // receive filter
  // ****************************************
  // filter ignored in shift mode; stop bit checked in async8; ninth bit in 9-bit modes
  always_comb begin
    accept = rx_frame.valid && !rx_complete_flag;
    if (multiproc_filter_enable_r) begin
      case (mode_r)
        umb_pkg::UMB_MODE_SHIFT: accept = accept;
        umb_pkg::UMB_MODE_ASYNC8: accept = accept && rx_stop_bit;
        default: accept = accept && rx_frame.ninth;
      endcase
    end
  end

  // complete flag: an accepted frame wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_complete_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (accept) begin
        rx_complete_flag <= 1'b1;
        rx_data <= rx_frame.data;
        // ninth bit in 9-bit modes, stop bit in async8
        rx_ninth_bit <= mode_r[1] ? rx_frame.ninth : rx_stop_bit;
      end else if (wr_acc && paddr == `UMB_ADDR_CTRL && pstrb[0] && !pwdata[`UMB_CTRL_RXF]) begin
        rx_complete_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  // control writes; baud register locked while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= umb_pkg::UMB_MODE_SHIFT;
      multiproc_filter_enable_r <= 1'b0;
      baud_run_r <= 1'b0;
      baud_prescale_sel_r <= `UMB_RST_PRE;
      reload_r <= {`UMB_RST_RELOAD, `UMB_RST_FRAC};
    end else if (wr_acc) begin
      if (paddr == `UMB_ADDR_CTRL) begin
        if (pstrb[0]) begin
          mode_r <= umb_pkg::umb_mode_t'(pwdata[`UMB_CTRL_MODE_MSB:`UMB_CTRL_MODE_LSB]);
          multiproc_filter_enable_r <= pwdata[`UMB_CTRL_MPF];
        end
      end else if (paddr == `UMB_ADDR_BAUD) begin
        if (!baud_run_r) begin
          // low byte lane carries reload low bits and fraction
          if (pstrb[0]) begin
            reload_r[7:0] <= pwdata[7:0];
          end
          if (pstrb[1]) begin
            reload_r[15:8] <= pwdata[15:8];
          end
        end
      end else if (paddr == `UMB_ADDR_BAUD_CONTROL) begin
        if (pstrb[0]) begin
          baud_run_r <= pwdata[`UMB_BAUD_CONTROL_RUN];
          baud_prescale_sel_r <= pwdata[`UMB_BAUD_CONTROL_PRE_MSB:`UMB_BAUD_CONTROL_PRE_LSB];
        end
      end
    end
  end

  // read mux: baud address returns live timer count with current fraction
  assign addr_ok = (paddr == `UMB_ADDR_CTRL) || (paddr == `UMB_ADDR_BAUD) ||
    (paddr == `UMB_ADDR_BAUD_CONTROL) || (paddr == `UMB_ADDR_RXBUF);
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr == `UMB_ADDR_CTRL) begin
      rdata_nxt[`UMB_CTRL_MODE_MSB:`UMB_CTRL_MODE_LSB] = mode_r;
      rdata_nxt[`UMB_CTRL_MPF] = multiproc_filter_enable_r;
      rdata_nxt[`UMB_CTRL_RXF] = rx_complete_flag;
      rdata_nxt[`UMB_CTRL_RB8] = rx_ninth_bit;
    end else if (paddr == `UMB_ADDR_BAUD) begin
      rdata_nxt[`UMB_BAUD_RELOAD_MSB:`UMB_BAUD_RELOAD_LSB] = timer_r;
      rdata_nxt[`UMB_BAUD_FRAC_MSB:0] = reload_r.frac;
    end else if (paddr == `UMB_ADDR_BAUD_CONTROL) begin
      rdata_nxt[`UMB_BAUD_CONTROL_RUN] = baud_run_r;
      rdata_nxt[`UMB_BAUD_CONTROL_PRE_MSB:`UMB_BAUD_CONTROL_PRE_LSB] = baud_prescale_sel_r;
    end else if (paddr == `UMB_ADDR_RXBUF) begin
      rdata_nxt[7:0] = rx_data;
    end
  end

  // no wait state: data captured in setup, ready raised in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_acc) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // bit rate ceiling: no two x16 pulses back to back
  baud_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    baud_x16_pulse |=> !baud_x16_pulse) else $error("x16 pulses adjacent");
  locked_baud_a: assert property (@(posedge pclk) disable iff (!presetn)
    baud_run_r |=> $stable(reload_r)) else $error("baud written while running");
  start_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(baud_run_r) |=> timer_r == reload_r.reload) else $error("timer not loaded at start");
  stopped_a: assert property (@(posedge pclk) disable iff (!presetn)
    !baud_run_r && run_d_r |=> $stable(timer_r)) else $error("timer moved while stopped");
  filter_nine_a: assert property (@(posedge pclk) disable iff (!presetn)
    multiproc_filter_enable_r && mode_r[1] && rx_frame.valid && !rx_frame.ninth && !rx_complete_flag
    |=> !rx_complete_flag) else $error("data byte passed filter");
  lost_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_complete_flag && rx_frame.valid |=> $stable(rx_data)) else $error("byte overwrote unread data");
  shift_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r == umb_pkg::UMB_MODE_SHIFT && $stable(mode_r) && bit_tick |=> !bit_tick ##1
    (bit_tick || mode_r != umb_pkg::UMB_MODE_SHIFT))
    else $error("shift mode rate wrong");
  stop_check_a: assert property (@(posedge pclk) disable iff (!presetn)
    multiproc_filter_enable_r && mode_r == umb_pkg::UMB_MODE_ASYNC8 && rx_frame.valid && !rx_stop_bit
    && !rx_complete_flag |=> !rx_complete_flag) else $error("bad stop bit accepted");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("apb ready late");
  rx_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_complete_flag));
  frac_c: cover property (@(posedge pclk) disable iff (!presetn) extra_r && gen_pulse == 1'b0 && pre_tick);
  bit_c: cover property (@(posedge pclk) disable iff (!presetn) bit_tick && var_mode(mode_r));

endmodule // umb_core

// ---- rtl/umb_pkg.sv ----
// types shared by the uart baud / multiproc block
// assumes umb_cfg.svh is on the include path
`include "umb_cfg.svh"
package umb_pkg;
  // ****************************************
  // modes and records
  // ****************************************
  typedef enum logic [1:0] {
    UMB_MODE_SHIFT = 2'h0,
    UMB_MODE_ASYNC8 = 2'h1,
    UMB_MODE_FIX9 = 2'h2,
    UMB_MODE_VAR9 = 2'h3
  } umb_mode_t;
  typedef struct packed {
    logic valid;
    logic ninth;
    logic [7:0] data;
  } umb_frame_t;
  typedef struct packed {
    logic [10:0] reload;
    logic [4:0] frac;
  } umb_baud_t;
endpackage

// ---- sim/tb_top.sv ----
// self-checking bench for the baud generator and multiprocessor filter
// assumes umb_cfg.svh on the include path and the apb slave answering with pready
`timescale 1ns/1ps
`include "umb_cfg.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, er, baud_x16_pulse, bit_tick, rx_complete_flag, rx_ninth_bit;
  logic [7:0] rx_data;
  umb_pkg::umb_frame_t rx_frame;
  logic rx_stop_bit;
  int fails, compares, c;
  umb_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .rx_stop_bit(rx_stop_bit), .baud_x16_pulse(baud_x16_pulse), .bit_tick(bit_tick),
    .rx_complete_flag(rx_complete_flag), .rx_ninth_bit(rx_ninth_bit), .rx_data(rx_data));
  umb_frame_src u_src (.pclk(pclk), .rx_frame(rx_frame), .rx_stop_bit(rx_stop_bit));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; wait bounded, data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // writing ctrl with bit3 low also clears the complete flag
  task automatic rx(input logic [1:0] m, input logic f, input logic nb, input logic [7:0] d, input logic st,
                    input logic ex);
    apb(1'b1, `UMB_ADDR_CTRL, {29'h0, f, m});
    u_src.send(nb, d, st);
    @(posedge pclk);
    chk(rx_complete_flag, ex);
    if (ex) begin
      chk(rx_data, d);
      chk(rx_ninth_bit, m[1] ? nb : st);
    end
  endtask
  // cycles spanned by k pulses of bit_tick (t=1) or of the x16 clock (t=0)
  task automatic per(input logic t, input int k, output int cnt);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while ((t ? bit_tick : baud_x16_pulse) !== 1'b1 && n < 5000);
    cnt = 0;
    repeat (k) begin
      do begin @(posedge pclk); cnt++; end while ((t ? bit_tick : baud_x16_pulse) !== 1'b1 && cnt < 20000);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    apb(1'b0, `UMB_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
  endtask
  task automatic t_filter;
    rx(umb_pkg::UMB_MODE_VAR9, 1'b1, 1'b0, 8'h5a, 1'b1, 1'b0);
    rx(umb_pkg::UMB_MODE_VAR9, 1'b1, 1'b1, 8'ha5, 1'b1, 1'b1);
    rx(umb_pkg::UMB_MODE_VAR9, 1'b0, 1'b0, 8'h3c, 1'b1, 1'b1);
    rx(umb_pkg::UMB_MODE_FIX9, 1'b1, 1'b0, 8'h0f, 1'b1, 1'b0);
  endtask
  task automatic t_other_modes;
    rx(umb_pkg::UMB_MODE_ASYNC8, 1'b1, 1'b1, 8'h11, 1'b0, 1'b0);
    rx(umb_pkg::UMB_MODE_ASYNC8, 1'b1, 1'b0, 8'h22, 1'b1, 1'b1);
    rx(umb_pkg::UMB_MODE_SHIFT, 1'b1, 1'b0, 8'h33, 1'b0, 1'b1);
  endtask
  task automatic t_overrun;
    rx(umb_pkg::UMB_MODE_VAR9, 1'b0, 1'b1, 8'h44, 1'b1, 1'b1);
    u_src.send(1'b0, 8'h55, 1'b1);
    @(posedge pclk);
    chk(rx_data, 8'h44);
  endtask
  task automatic t_fixed;
    apb(1'b1, `UMB_ADDR_CTRL, 32'h2);
    per(1'b1, 4, c);
    chk(c, 256);
    apb(1'b1, `UMB_ADDR_CTRL, 32'h0);
    per(1'b1, 8, c);
    chk(c, 16);
  endtask
  // reload 2 is the fastest legal setting: one bit every 32 pclk
  task automatic t_baud;
    apb(1'b1, `UMB_ADDR_CTRL, 32'h1);
    apb(1'b1, `UMB_ADDR_BAUD, 32'h0040);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `UMB_ADDR_BAUD_CONTROL, (s << 1) | 1);
      per(1'b0, 8, c);
      chk(c, 16 << s);
      apb(1'b1, `UMB_ADDR_BAUD_CONTROL, 32'h0);
    end
    apb(1'b1, `UMB_ADDR_BAUD_CONTROL, 32'h1);
    per(1'b1, 2, c);
    chk(c, 64);
    apb(1'b1, `UMB_ADDR_BAUD, 32'h00a0);
    per(1'b0, 8, c);
    chk(c, 16);
  endtask
  // reload 3 with fraction 5: any 32 periods hold five extra counts
  task automatic t_frac;
    apb(1'b1, `UMB_ADDR_BAUD_CONTROL, 32'h0);
    apb(1'b1, `UMB_ADDR_BAUD, 32'h0065);
    apb(1'b1, `UMB_ADDR_BAUD_CONTROL, 32'h1);
    per(1'b0, 32, c);
    chk(c, 101);
  endtask
  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    fails = 0; compares = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_filter;
    t_other_modes;
    t_overrun;
    t_fixed;
    t_baud;
    t_frac;
    end_sim;
  end
  // run needs about a thousand cycles; far longer means a hang
  initial begin
    #1250000;
    fails++;
    end_sim;
  end
endmodule // tb_top

// ---- sim/umb_frame_src.sv ----
// far-side model: the frame deserialiser and the remote nodes behind it
// assumes pclk from the bench; frames change just after a rising edge
`timescale 1ns/1ps
module umb_frame_src (
  input wire logic pclk,
  output umb_pkg::umb_frame_t rx_frame,
  output logic rx_stop_bit
);
  // ****************************************
  // frame pulses
  // ****************************************
  initial begin
    rx_frame = '0;
    rx_stop_bit = 1'b0;
  end
  // one-cycle valid; payload inverted after it so a stale byte never looks fresh
  task automatic send(input logic ninth, input logic [7:0] data, input logic stop);
    @(posedge pclk);
    rx_frame <= '{valid: 1'b1, ninth: ninth, data: data};
    rx_stop_bit <= stop;
    @(posedge pclk);
    rx_frame <= '{valid: 1'b0, ninth: ~ninth, data: ~data};
    rx_stop_bit <= ~stop;
  endtask
endmodule // umb_frame_src
